// ---- src/ipc_controller.sv ----
// interrupt enable, priority, flag and vector logic
`timescale 1ns/1ps
// Notes on behaviour
// - vectors 0003h, 000Bh, 0013h for ext0, timer0, ext1
// - vectors 001Bh, 0023h, 002Bh; reset uses 0000h
// - blank byte FFh at zero starts loader
// - global enable bit 7 gates every source
// - enable bits 5..0 per source, bit 6 reserved
// - reset clears whole enable register
// - single bits writable alone
// - trigger type one: falling pin edge requests
// - trigger type zero: low pin level requests
// - external flags set on trigger, software readable
// - edge external flag cleared on vectoring
// - timer rollover requests, not timer zero mode3
// - timer zero/one flags cleared on vectoring
// - timer two request is overflow OR event
// - software writes to flags act like hardware
// - serial flags share request, never auto cleared
// - accepting request sets in-service, jumps vector
// - return instruction clears the in-service level
// - equal level order ext0,timer0,ext1,timer1,serial,timer2
// - priority register bits give high level
module ipc_controller
    import ipc_pkg::*;
#(
    parameter logic [15:0] LOADER_START = 16'hf000
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_bit_addr,
    input wire logic sfr_bit_val,
    input wire logic sfr_bit_wr,
    output logic [7:0] sfr_rdata,
    input wire logic ext_request_pin_zero,
    input wire logic ext_request_pin_one,
    input wire logic timer0_rollover,
    input wire logic timer0_mode3,
    input wire logic timer1_rollover,
    input wire logic timer2_overflow_flag,
    input wire logic timer2_external_flag,
    input wire logic serial_rx_done_flag,
    input wire logic serial_tx_done_flag,
    input wire logic irq_accept,
    input wire logic return_from_irq,
    input wire logic [7:0] boot_byte_zero,
    output logic irq_request,
    output logic [15:0] irq_vector,
    output logic irq_high_level,
    output logic [1:0] irq_in_service,
    output logic start_vector_valid,
    output logic [15:0] start_vector,
    output logic timer0_overflow_flag,
    output logic timer1_overflow_flag
);
    // all flip-flops in one record
    typedef struct packed {
        logic [7:0] interrupt_enable;   // enable register
        logic [7:0] interrupt_priority; // priority register
        logic [7:0] timer_control_reg;  // flag and trigger type bits
        logic [7:0] rdata;              // registered read data
        logic irq_req;                  // request towards the core
        logic [15:0] vec; // presented vector
        logic [2:0] src; // presented source
        logic hi; // presented level
        logic [1:0] in_service;         // bit 1 high level, bit 0 low level
        logic boot_done;                // start vector has been decided
        logic [15:0] boot_vec;          // decided start vector
    } ipc_state_t;

    ipc_state_t state_reg;  // registered state
    ipc_state_t state_next; // next state

    // synchronised pins and their falling edges
    logic [1:0] pin_level;
    logic [1:0] pin_fall;

    // pending requests split by level, and the winner
    logic [IPC_SRC_COUNT-1:0] req_all;
    logic [IPC_SRC_COUNT-1:0] req_high;
    logic [IPC_SRC_COUNT-1:0] req_low;
    logic pick_valid;
    logic pick_high;
    logic [2:0] pick_index;

    // bit address falls inside the register at base
    function automatic logic ipc_bit_hit(input logic [7:0] bit_addr,
                                         input logic [7:0] base);
        ipc_bit_hit = (bit_addr[7:3] == base[7:3]);
    endfunction : ipc_bit_hit

    // byte or single bit write to one register
    function automatic logic [7:0] ipc_apply(input logic [7:0] cur,
                                             input logic [7:0] base,
                                             input logic [7:0] mask);
        logic [7:0] val;
        val = cur;
        if (sfr_wr && (sfr_addr == base)) begin
            val = sfr_wdata;
        end else if (sfr_bit_wr && ipc_bit_hit(sfr_bit_addr, base)) begin
            val[sfr_bit_addr[2:0]] = sfr_bit_val;
        end
        ipc_apply = val & mask;
    endfunction : ipc_apply

    // request pins pass two flip-flops before use
    ipc_pin_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .pin_async({ext_request_pin_one, ext_request_pin_zero}),
        .pin_level(pin_level),
        .pin_fall(pin_fall)
    );

    // gather the enabled requests from the flags
    always_comb begin
        req_all[IPC_EXT0_BIT] = state_reg.timer_control_reg[IPC_TC_EXT0_FLAG];
        req_all[IPC_TIMER0_BIT] = state_reg.timer_control_reg[IPC_TC_TIMER0_FLAG];
        req_all[IPC_EXT1_BIT] = state_reg.timer_control_reg[IPC_TC_EXT1_FLAG];
        req_all[IPC_TIMER1_BIT] = state_reg.timer_control_reg[IPC_TC_TIMER1_FLAG];
        // receive and transmit share one request
        req_all[IPC_SERIAL_BIT] = serial_rx_done_flag | serial_tx_done_flag;
        // overflow and external event share one request
        req_all[IPC_TIMER2_BIT] = timer2_overflow_flag | timer2_external_flag;
        // per-source gate, then the global gate
        req_all = req_all & state_reg.interrupt_enable[IPC_SRC_COUNT-1:0];
        if (!state_reg.interrupt_enable[IPC_GLOBAL_EN_BIT]) begin
            req_all = '0;
        end
        // high level only while no high routine runs
        req_high = req_all & state_reg.interrupt_priority[IPC_SRC_COUNT-1:0];
        if (state_reg.in_service[1]) begin
            req_high = '0;
        end
        // low level only while nothing runs at all
        req_low = req_all & ~state_reg.interrupt_priority[IPC_SRC_COUNT-1:0];
        if (state_reg.in_service != 2'b00) begin
            req_low = '0;
        end
    end

    // pick the winner; natural order inside each level
    ipc_prio_pick #(
        .SRC(IPC_SRC_COUNT)
    ) u_prio_pick (
        .req_high(req_high),
        .req_low(req_low),
        .pick_valid(pick_valid),
        .pick_high(pick_high),
        .pick_index(pick_index)
    );

    // next state of every register
    always_comb begin
        logic tc_edge0;
        logic tc_edge1;
        logic set_ext0;
        logic set_ext1;
        logic set_tf0;
        logic set_tf1;
        logic clr_ext0;
        logic clr_ext1;
        logic clr_tf0;
        logic clr_tf1;
        state_next = state_reg;
        tc_edge0 = state_reg.timer_control_reg[IPC_TC_EXT0_TYPE];
        tc_edge1 = state_reg.timer_control_reg[IPC_TC_EXT1_TYPE];

        // software byte and bit writes
        state_next.interrupt_enable = ipc_apply(state_reg.interrupt_enable,
                                                IPC_ADDR_IE, IPC_IE_MASK);
        state_next.interrupt_priority = ipc_apply(state_reg.interrupt_priority,
                                                  IPC_ADDR_IP, IPC_IP_MASK);
        // flag writes act like hardware
        state_next.timer_control_reg = ipc_apply(state_reg.timer_control_reg,
                                                 IPC_ADDR_TIMER_CONTROL_REG, IPC_TIMER_CONTROL_REG_MASK);

        // hardware sets: edge or level per trigger type
        set_ext0 = tc_edge0 ? pin_fall[0] : ~pin_level[0];
        set_ext1 = tc_edge1 ? pin_fall[1] : ~pin_level[1];
        // timer zero in mode 3 does not request
        set_tf0 = timer0_rollover & ~timer0_mode3;
        set_tf1 = timer1_rollover;

        // clears on vectoring; level external flags are left alone
        clr_ext0 = irq_accept && state_reg.src == 3'(IPC_EXT0_BIT) && tc_edge0;
        clr_ext1 = irq_accept && state_reg.src == 3'(IPC_EXT1_BIT) && tc_edge1;
        clr_tf0 = irq_accept && state_reg.src == 3'(IPC_TIMER0_BIT);
        clr_tf1 = irq_accept && state_reg.src == 3'(IPC_TIMER1_BIT);

        // clear, then set: a same-cycle event wins
        if (clr_ext0) begin
            state_next.timer_control_reg[IPC_TC_EXT0_FLAG] = 1'b0;
        end
        if (clr_ext1) begin
            state_next.timer_control_reg[IPC_TC_EXT1_FLAG] = 1'b0;
        end
        if (clr_tf0) begin
            state_next.timer_control_reg[IPC_TC_TIMER0_FLAG] = 1'b0;
        end
        if (clr_tf1) begin
            state_next.timer_control_reg[IPC_TC_TIMER1_FLAG] = 1'b0;
        end
        if (set_ext0) begin
            state_next.timer_control_reg[IPC_TC_EXT0_FLAG] = 1'b1;
        end
        if (set_ext1) begin
            state_next.timer_control_reg[IPC_TC_EXT1_FLAG] = 1'b1;
        end
        if (set_tf0) begin
            state_next.timer_control_reg[IPC_TC_TIMER0_FLAG] = 1'b1;
        end
        if (set_tf1) begin
            state_next.timer_control_reg[IPC_TC_TIMER1_FLAG] = 1'b1;
        end

        // accept sets a level, return clears the top one
        if (irq_accept && state_reg.irq_req) begin
            if (state_reg.hi) begin
                state_next.in_service[1] = 1'b1;
            end else begin
                state_next.in_service[0] = 1'b1;
            end
        end else if (return_from_irq) begin
            if (state_reg.in_service[1]) begin
                state_next.in_service[1] = 1'b0;
            end else begin
                state_next.in_service[0] = 1'b0;
            end
        end

        // present the winner; drop it when taken
        if (irq_accept) begin
            state_next.irq_req = 1'b0;
        end else begin
            state_next.irq_req = pick_valid;
            state_next.src = pick_index;
            state_next.hi = pick_high;
            state_next.vec = IPC_VECTOR[pick_index];
        end

        // registered read; unmapped reads zero
        if (!sfr_rd) begin
            state_next.rdata = state_reg.rdata;
        end else if (sfr_addr == IPC_ADDR_IE) begin
            state_next.rdata = state_reg.interrupt_enable;
        end else if (sfr_addr == IPC_ADDR_IP) begin
            state_next.rdata = state_reg.interrupt_priority;
        end else if (sfr_addr == IPC_ADDR_TIMER_CONTROL_REG) begin
            state_next.rdata = state_reg.timer_control_reg;
        end else begin
            state_next.rdata = 8'h00;
        end

        // choose the start vector once, one edge after reset release
        if (!state_reg.boot_done) begin
            state_next.boot_done = 1'b1;
            if (boot_byte_zero == IPC_BLANK_BYTE) begin
                state_next.boot_vec = LOADER_START;
            end else begin
                state_next.boot_vec = IPC_RESET_VECTOR;
            end
        end
    end

    // the single state register
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_reg.interrupt_enable <= IPC_REG_RESET;
            state_reg.interrupt_priority <= IPC_REG_RESET;
            state_reg.timer_control_reg <= IPC_REG_RESET;
            state_reg.rdata <= 8'h00;
            state_reg.irq_req <= 1'b0;
            state_reg.vec <= IPC_RESET_VECTOR;
            state_reg.src <= 3'h0;
            state_reg.hi <= 1'b0;
            state_reg.in_service <= 2'b00;
            state_reg.boot_done <= 1'b0;
            state_reg.boot_vec <= IPC_RESET_VECTOR;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs from the flip-flops
    assign sfr_rdata = state_reg.rdata;
    assign irq_request = state_reg.irq_req;
    assign irq_vector = state_reg.vec;
    assign irq_high_level = state_reg.hi;
    assign irq_in_service = state_reg.in_service;
    assign start_vector_valid = state_reg.boot_done;
    assign start_vector = state_reg.boot_vec;
    assign timer0_overflow_flag = state_reg.timer_control_reg[IPC_TC_TIMER0_FLAG];
    assign timer1_overflow_flag = state_reg.timer_control_reg[IPC_TC_TIMER1_FLAG];
endmodule : ipc_controller

// ---- shared/ipc_pkg.sv ----
// constants of the interrupt priority controller
package ipc_pkg;
    // number of maskable interrupt sources
    localparam int IPC_SRC_COUNT = 6;
    // special function register byte addresses
    localparam logic [7:0] IPC_ADDR_IE = 8'ha8;
    localparam logic [7:0] IPC_ADDR_IP = 8'hb8;
    localparam logic [7:0] IPC_ADDR_TIMER_CONTROL_REG = 8'h88;
    // writable interrupt_enable bits
    localparam logic [7:0] IPC_IE_MASK = 8'hbf;
    // writable interrupt_priority bits
    localparam logic [7:0] IPC_IP_MASK = 8'h3f;
    // bits of timer_control_reg kept in this block
    localparam logic [7:0] IPC_TIMER_CONTROL_REG_MASK = 8'haf;
    // reset value of all three registers
    localparam logic [7:0] IPC_REG_RESET = 8'h00;
    // field positions in interrupt_enable and interrupt_priority
    localparam int IPC_GLOBAL_EN_BIT = 7;
    localparam int IPC_EXT0_BIT = 0;
    localparam int IPC_TIMER0_BIT = 1;
    localparam int IPC_EXT1_BIT = 2;
    localparam int IPC_TIMER1_BIT = 3;
    localparam int IPC_SERIAL_BIT = 4;
    localparam int IPC_TIMER2_BIT = 5;
    // field positions in timer_control_reg
    localparam int IPC_TC_EXT0_TYPE = 0;
    localparam int IPC_TC_EXT0_FLAG = 1;
    localparam int IPC_TC_EXT1_TYPE = 2;
    localparam int IPC_TC_EXT1_FLAG = 3;
    localparam int IPC_TC_TIMER0_FLAG = 5;
    localparam int IPC_TC_TIMER1_FLAG = 7;
    // vector addresses, indexed by source number
    localparam logic [5:0][15:0] IPC_VECTOR = {
        16'h002b, 16'h0023, 16'h001b, 16'h0013, 16'h000b, 16'h0003
    };
    // vector used at reset when the byte at zero is programmed
    localparam logic [15:0] IPC_RESET_VECTOR = 16'h0000;
    // erased byte at location zero: start the loader
    localparam logic [7:0] IPC_BLANK_BYTE = 8'hff;
    // least pin level hold, in oscillator cycles
    localparam int IPC_EDGE_HOLD_OSC = 12;
endpackage : ipc_pkg

// ---- src/ipc_pin_sync.sv ----
// two-flop synchroniser and fall detector for pins
`timescale 1ns/1ps
module ipc_pin_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [WIDTH-1:0] pin_async,
    output logic [WIDTH-1:0] pin_level,
    output logic [WIDTH-1:0] pin_fall
);
    // two stages synchronise, a third sees the edge
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_pin
            // idle pins are high, so reset to high to avoid a false edge
            always_ff @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    stage1_reg[g] <= 1'b1;
                    stage2_reg[g] <= 1'b1;
                    stage3_reg[g] <= 1'b1;
                end else begin
                    stage1_reg[g] <= pin_async[g];
                    stage2_reg[g] <= stage1_reg[g];
                    stage3_reg[g] <= stage2_reg[g];
                end
            end
            // only the second and third stages are looked at
            assign pin_level[g] = stage2_reg[g];
            assign pin_fall[g] = stage3_reg[g] & ~stage2_reg[g];
        end
    endgenerate
endmodule : ipc_pin_sync

// ---- src/ipc_prio_pick.sv ----
// two-level priority picker over the pending sources
`timescale 1ns/1ps
module ipc_prio_pick #(
    parameter int SRC = 6
) (
    input wire logic [SRC-1:0] req_high,
    input wire logic [SRC-1:0] req_low,
    output logic pick_valid,
    output logic pick_high,
    output logic [2:0] pick_index
);
    // high level first, lowest index within a level
    always_comb begin
        pick_valid = 1'b0;
        pick_high = 1'b0;
        pick_index = 3'h0;
        for (int i = SRC - 1; i >= 0; i--) begin
            if (req_low[i]) begin
                pick_valid = 1'b1;
                pick_index = 3'(i);
            end
        end
        for (int i = SRC - 1; i >= 0; i--) begin
            if (req_high[i]) begin
                pick_valid = 1'b1;
                pick_high = 1'b1;
                pick_index = 3'(i);
            end
        end
    end
endmodule : ipc_prio_pick

// ---- verification/ipc_controller_assertions.sv ----
// port-level assertions and covers for the interrupt priority controller
`timescale 1ns/1ps
module ipc_controller_checker
    import ipc_pkg::*;
#(
    parameter logic [15:0] LOADER_START = 16'hf000
) (
    input logic clk_sys,
    input logic reset,
    input logic sfr_rd,
    input logic sfr_wr,
    input logic sfr_bit_wr,
    input logic [7:0] sfr_rdata,
    input logic timer0_rollover,
    input logic timer0_mode3,
    input logic irq_accept,
    input logic return_from_irq,
    input logic [7:0] boot_byte_zero,
    input logic irq_request,
    input logic [15:0] irq_vector,
    input logic irq_high_level,
    input logic [1:0] irq_in_service,
    input logic start_vector_valid,
    input logic [15:0] start_vector,
    input logic timer0_overflow_flag
);
    // one clock domain
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_vector_in_table: assert property (irq_request |-> irq_vector inside
        {16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b})
        else $error("bad vector");
    a_start_vector_pick: assert property ($rose(start_vector_valid) |-> start_vector ==
        ((boot_byte_zero == IPC_BLANK_BYTE) ? LOADER_START : IPC_RESET_VECTOR))
        else $error("bad start vector");
    a_accept_drops_req: assert property (irq_request && irq_accept |=> !irq_request)
        else $error("request held");
    a_low_accept_marks: assert property (irq_request && irq_accept && !irq_high_level
        |=> irq_in_service[0]) else $error("low in-service unset");
    a_high_accept_marks: assert property (irq_request && irq_accept && irq_high_level
        |=> irq_in_service[1]) else $error("high in-service unset");
    a_return_nested: assert property (return_from_irq && !irq_accept &&
        irq_in_service == 2'b11 |=> irq_in_service == 2'b01) else $error("nested return");
    a_return_single: assert property (return_from_irq && !irq_accept &&
        irq_in_service == 2'b01 |=> irq_in_service == 2'b00) else $error("low return");
    a_low_waits: assert property (|irq_in_service |-> !(irq_request && !irq_high_level))
        else $error("low request in routine");
    a_high_waits: assert property (irq_in_service[1] |-> !irq_request)
        else $error("request in high routine");
    a_rollover_sets: assert property (timer0_rollover && !timer0_mode3
        |=> timer0_overflow_flag) else $error("no rollover flag");
    a_mode3_ignores: assert property (timer0_rollover && timer0_mode3 && !sfr_wr &&
        !sfr_bit_wr && !timer0_overflow_flag |=> !timer0_overflow_flag)
        else $error("mode 3 flagged");
    a_vector_clears_t0: assert property (irq_request && irq_accept && !sfr_bit_wr &&
        !sfr_wr && irq_vector == 16'h000b && !timer0_rollover |=> !timer0_overflow_flag)
        else $error("timer0 flag kept");
    a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved");
    // main scenarios
    c_low_taken: cover property (irq_accept && irq_request && !irq_high_level);
    c_high_taken: cover property (irq_accept && irq_request && irq_high_level);
    c_nested: cover property (irq_in_service == 2'b11);
endmodule : ipc_controller_checker

bind ipc_controller ipc_controller_checker #(.LOADER_START(LOADER_START)) chk_i (
    .clk_sys, .reset, .sfr_rd, .sfr_wr, .sfr_bit_wr, .sfr_rdata, .timer0_rollover,
    .timer0_mode3, .irq_accept, .return_from_irq, .boot_byte_zero, .irq_request,
    .irq_vector, .irq_high_level, .irq_in_service, .start_vector_valid, .start_vector,
    .timer0_overflow_flag);

// ---- verification/ipc_core_model.sv ----
// behavioural processor core that takes requests and runs routines
`timescale 1ns/1ps
module ipc_core_model (
    input logic clk_sys,
    input logic irq_request,
    input logic [15:0] irq_vector,
    input logic irq_high_level,
    input logic auto_en,
    input logic [3:0] wait_cycles,
    output logic irq_accept,
    output logic return_from_irq,
    output int n_taken,
    output logic [15:0] taken_vector,
    output logic taken_high
);
    int waited; // stall cycles so far
    initial begin
        irq_accept = 1'b0;
        return_from_irq = 1'b0;
        n_taken = 0;
        waited = 0;
    end
    // take a request after the stall, for one edge
    always @(posedge clk_sys) begin
        if (irq_accept) begin
            taken_vector <= irq_vector;
            taken_high <= irq_high_level;
            n_taken <= n_taken + 1;
            waited <= 0;
            irq_accept <= #1 1'b0;
        end else if (irq_request && auto_en) begin
            if (waited >= wait_cycles) irq_accept <= #1 1'b1;
            else waited <= waited + 1;
        end else begin
            waited <= 0;
        end
    end
    // one return pulse, launched just after an edge
    task automatic end_routine;
        @(posedge clk_sys);
        #1 return_from_irq = 1'b1;
        @(posedge clk_sys);
        #1 return_from_irq = 1'b0;
    endtask : end_routine
endmodule : ipc_core_model

// ---- verification/ipc_controller_tb.sv ----
// self-checking bench for the interrupt priority controller
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module ipc_controller_tb;
    import ipc_pkg::*;
    localparam logic [15:0] LOADER = 16'h1234; // loader entry, value arbitrary
    logic clk_sys, reset, sfr_wr, sfr_rd, sfr_bit_val, sfr_bit_wr;
    logic [7:0] sfr_addr, sfr_wdata, sfr_bit_addr, sfr_rdata, boot_byte_zero;
    logic ext_request_pin_zero, ext_request_pin_one, timer0_rollover, timer0_mode3;
    logic timer1_rollover, timer2_overflow_flag, timer2_external_flag;
    logic serial_rx_done_flag, serial_tx_done_flag, irq_accept, return_from_irq;
    logic irq_request, irq_high_level, start_vector_valid, t0_flag, t1_flag, auto_en;
    logic [15:0] irq_vector, start_vector, taken_vector;
    logic [1:0] irq_in_service;
    logic [3:0] wait_cycles;
    logic taken_high;
    int n_taken, num_errors = 0, n_tests = 0, cycles = 0;
    ipc_controller #(.LOADER_START(LOADER)) ipc_controller_i (
        .clk_sys, .reset, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_bit_addr,
        .sfr_bit_val, .sfr_bit_wr, .sfr_rdata, .ext_request_pin_zero, .ext_request_pin_one,
        .timer0_rollover, .timer0_mode3, .timer1_rollover, .timer2_overflow_flag,
        .timer2_external_flag, .serial_rx_done_flag, .serial_tx_done_flag, .irq_accept,
        .return_from_irq, .boot_byte_zero, .irq_request, .irq_vector, .irq_high_level,
        .irq_in_service, .start_vector_valid, .start_vector,
        .timer0_overflow_flag(t0_flag), .timer1_overflow_flag(t1_flag));
    ipc_core_model ipc_core_model_i (
        .clk_sys, .irq_request, .irq_vector, .irq_high_level, .auto_en, .wait_cycles,
        .irq_accept, .return_from_irq, .n_taken, .taken_vector, .taken_high);
    // 25 MHz core clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // verdict and end of run
    task automatic close_out;
        if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end
    // n edges, then 1 ns on
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    // one-cycle strobe
    task automatic pulse(ref logic s);
        tick(1);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask : pulse
    // byte write, bit write and checked byte read
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        pulse(sfr_wr);
    endtask : wr
    task automatic wb(input logic [7:0] a, input logic v);
        sfr_bit_addr = a;
        sfr_bit_val = v;
        pulse(sfr_bit_wr);
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr = a;
        pulse(sfr_rd);
        `CHK(sfr_rdata, exp)
    endtask : rd
    // await a take; check it
    task automatic taken(input logic [15:0] v, input logic h);
        int k;
        k = n_taken;
        for (int i = 0; i < 40 && n_taken == k; i++) tick(1);
        `CHK(n_taken, k + 1)
        `CHK(taken_vector, v)
        `CHK(taken_high, h)
    endtask : taken
    // end the running routine through the core model
    task automatic leave;
        ipc_core_model_i.end_routine();
    endtask : leave
    initial begin
        {sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, timer0_rollover, timer0_mode3} = '0;
        {timer1_rollover, timer2_overflow_flag, timer2_external_flag} = '0;
        {serial_rx_done_flag, serial_tx_done_flag, sfr_addr, sfr_wdata, sfr_bit_addr} = '0;
        {ext_request_pin_zero, ext_request_pin_one, auto_en} = 3'b111;
        boot_byte_zero = 8'hff;
        wait_cycles = 4'h0;
        reset = 1'b1;
        tick(4);
        reset = 1'b0;
        // reset state, reserved bits, single-bit writes
        tick(1);
        `CHK(start_vector, LOADER)
        `CHK(start_vector_valid, 1'b1)
        rd(IPC_ADDR_IE, 8'h00);
        rd(IPC_ADDR_IP, 8'h00);
        rd(8'h90, 8'h00);
        wr(IPC_ADDR_IE, 8'hff);
        rd(IPC_ADDR_IE, 8'hbf);
        wr(IPC_ADDR_IP, 8'hff);
        rd(IPC_ADDR_IP, 8'h3f);
        wb(8'haf, 1'b0);
        wb(8'ha8, 1'b0);
        rd(IPC_ADDR_IE, 8'h3e);
        wr(IPC_ADDR_IP, 8'h00);
        // global enable off; software clears and sets the flag
        wr(IPC_ADDR_IE, 8'h02);
        pulse(timer0_rollover);
        tick(4);
        `CHK(t0_flag, 1'b1)
        `CHK(n_taken, 0)
        wb(8'h8d, 1'b0);
        `CHK(t0_flag, 1'b0)
        wr(IPC_ADDR_IE, 8'h82);
        wb(8'h8d, 1'b1);
        taken(16'h000b, 1'b0);
        `CHK(t0_flag, 1'b0)
        `CHK(irq_in_service, 2'b01)
        leave();
        `CHK(irq_in_service, 2'b00)
        // mode 3 ignores rollover, normal mode requests
        timer0_mode3 = 1'b1;
        pulse(timer0_rollover);
        tick(3);
        `CHK(t0_flag, 1'b0)
        timer0_mode3 = 1'b0;
        pulse(timer0_rollover);
        taken(16'h000b, 1'b0);
        leave();
        // edge-triggered ext1, flag read then cleared by vectoring
        auto_en = 1'b0;
        wr(IPC_ADDR_IE, 8'h84);
        wb(8'h8a, 1'b1);
        ext_request_pin_one = 1'b0;
        tick(3);
        ext_request_pin_one = 1'b1;
        tick(4);
        rd(IPC_ADDR_TIMER_CONTROL_REG, 8'h0c);
        auto_en = 1'b1;
        taken(16'h0013, 1'b0);
        rd(IPC_ADDR_TIMER_CONTROL_REG, 8'h04);
        leave();
        // all six pending at low level: natural order, slow core
        auto_en = 1'b0;
        wait_cycles = 4'h3;
        wr(IPC_ADDR_TIMER_CONTROL_REG, 8'h00);
        wr(IPC_ADDR_IE, 8'hbf);
        {ext_request_pin_zero, ext_request_pin_one} = 2'b00;
        {timer2_external_flag, serial_rx_done_flag, serial_tx_done_flag} = 3'b111;
        pulse(timer0_rollover);
        pulse(timer1_rollover);
        tick(4);
        auto_en = 1'b1;
        for (int i = 0; i < IPC_SRC_COUNT; i++) begin
            taken(16'h0003 + 16'(8 * i), 1'b0);
            // routine clears its own cause; timer zero/one flags clear on vectoring
            case (i)
                0: begin ext_request_pin_zero = 1'b1; tick(4); wb(8'h89, 1'b0); end
                2: begin ext_request_pin_one = 1'b1; tick(4); wb(8'h8b, 1'b0); end
                4: {serial_rx_done_flag, serial_tx_done_flag} = 2'b00;
                5: timer2_external_flag = 1'b0;
                default: ;
            endcase
            leave();
        end
        // high level preempts a low routine; equal level waits
        wr(IPC_ADDR_IP, 8'h20);
        pulse(timer1_rollover);
        `CHK(t1_flag, 1'b1)
        taken(16'h001b, 1'b0);
        `CHK(t1_flag, 1'b0)
        pulse(timer0_rollover);
        tick(4);
        `CHK(irq_request, 1'b0)
        timer2_overflow_flag = 1'b1;
        taken(16'h002b, 1'b1);
        `CHK(irq_in_service, 2'b11)
        timer2_overflow_flag = 1'b0;
        leave();
        `CHK(irq_in_service, 2'b01)
        leave();
        taken(16'h000b, 1'b0);
        leave();
        // mid-run reset with a programmed byte at zero
        boot_byte_zero = 8'h00;
        reset = 1'b1;
        tick(1);
        reset = 1'b0;
        tick(1);
        `CHK(start_vector, IPC_RESET_VECTOR)
        rd(IPC_ADDR_IE, 8'h00);
        close_out();
    end
endmodule : ipc_controller_tb
